// ===== logic/ucs_pkg.sv
// Package with register addresses, field positions and reset values.
package ucs_pkg;
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_IEN    = 3'h1;
  localparam logic [2:0] ADDR_ISRC   = 3'h2;
  localparam logic [2:0] ADDR_LFC    = 3'h3;
  localparam logic [2:0] ADDR_MOC    = 3'h4;
  localparam logic [2:0] ADDR_LST    = 3'h5;
  localparam logic [2:0] ADDR_MIS    = 3'h6;
  localparam logic [2:0] ADDR_SCR    = 3'h7;
  localparam int IEN_RX    = 0;
  localparam int IEN_TX    = 1;
  localparam int IEN_LS    = 2;
  localparam int IEN_MS    = 3;
  localparam int IEN_SPEC  = 5;
  localparam int LFC_STOP  = 2;
  localparam int LFC_PEN   = 3;
  localparam int LFC_EVEN  = 4;
  localparam int LFC_FORCE = 5;
  localparam int LFC_BRK   = 6;
  localparam int LFC_DLAB  = 7;
  localparam int MOC_DTR   = 0;
  localparam int MOC_RTS   = 1;
  localparam int MOC_AUX1  = 2;
  localparam int MOC_AUX2  = 3;
  localparam int MOC_LOOP  = 4;
  localparam int MOC_PDN   = 7;
  localparam logic [7:0] IEN_WMASK = 8'h2F;
  localparam logic [7:0] MOC_WMASK = 8'h9F;
  localparam logic [7:0] MOC_SPEC_BITS = 8'h84;
  localparam logic [7:0] SCR_RESET = 8'hFF;
  localparam logic [3:0] SRC_LS   = 4'h6;
  localparam logic [3:0] SRC_RX   = 4'h4;
  localparam logic [3:0] SRC_TX   = 4'h2;
  localparam logic [3:0] SRC_MS   = 4'h0;
  localparam logic [3:0] SRC_NONE = 4'h1;
  localparam logic [3:0] DATA_LEN_BASE = 4'h5;
  // Stop length counted in half bit times.
  localparam logic [2:0] STOP_ONE    = 3'h2;
  localparam logic [2:0] STOP_ONE_HALF = 3'h3;
  localparam logic [2:0] STOP_TWO    = 3'h4;
endpackage

// ===== logic/ucs_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ucs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // Pointers wrap through the whole array; depth is a power of two.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset; only the pointers matter.
  always_ff @(posedge clock_i)
  begin
    if (push)
      mem[wr_q] <= in_data_i;
  end
endmodule // ucs_fifo

// ===== logic/ucs_ctrl.sv
// Register file, interrupt prioritiser and modem control of the UART.
`timescale 1ns/1ps
module ucs_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic [7:0]      rdata_o,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  input  wire logic       tx_ready_i,
  output logic            tx_hold_ready_o,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic [3:0] rx_err_i,
  input  wire logic       tx_idle_i,
  input  wire logic [3:0] modem_delta_i,
  input  wire logic [3:0] modem_level_i,
  output logic [3:0]      char_len_o,
  output logic [2:0]      stop_halves_o,
  output logic            parity_en_o,
  output logic            parity_even_o,
  output logic            parity_forced_o,
  output logic            parity_force_val_o,
  output logic            tx_break_o,
  output logic [15:0]     divisor_o,
  output logic            loopback_o,
  output logic            power_down_o,
  output logic            dtr_n_o,
  output logic            rts_n_o,
  output logic            ring_indicator_in_n_o,
  output logic            carrier_detect_in_n_o,
  output logic            irq_o,
  output logic            irq_oe_n_o,
  output logic            reset_buf_o,
  input  wire logic       hw_reset_i
);
  typedef struct packed {
    logic [7:0] ien;
    logic [7:0] lfc;
    logic [7:0] moc;
    logic [7:0] scr;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [7:0] rxh;
    logic       rx_full;
    logic [3:0] err;
    logic       ls_pend;
    logic       tx_pend;
    logic       ms_pend;
    logic [3:0] mdelta;
    logic [7:0] rdata;
    logic       hr_s1;
    logic       hr_s2;
  } ucs_state_s;

  ucs_state_s q;
  ucs_state_s d;
  logic       rd_ev;
  logic       wr_ev;
  logic       dlab;
  logic       spec;
  logic       thr_empty;
  logic [7:0] lst;
  logic [3:0] src;
  logic       f_valid;
  logic [7:0] f_data;
  logic       f_ready;

  // Transmit bytes queue here; the shifter drains at its own pace.
  ucs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_data_i   (wdata_i),
    .in_valid_i  (wr_ev && addr_i == ucs_pkg::ADDR_DATA && !dlab),
    .in_ready_o  (f_ready),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (tx_ready_i)
  );

  assign rd_ev = rd_i;
  assign wr_ev = wr_i;
  assign dlab  = q.lfc[ucs_pkg::LFC_DLAB];
  assign spec  = q.ien[ucs_pkg::IEN_SPEC];
  // Holding is empty once the queue has drained into the shifter.
  assign thr_empty = !f_valid;
  assign tx_valid_o = f_valid;
  assign tx_data_o  = f_data;
  assign tx_hold_ready_o = f_ready;

  // Line status word; bit 7 reserved reads zero.
  assign lst = {1'b0, thr_empty && tx_idle_i, thr_empty, q.err,
                q.rx_full};

  // Fixed-priority source encoder.
  always_comb
  begin
    if (q.ls_pend && q.ien[ucs_pkg::IEN_LS])
      src = ucs_pkg::SRC_LS;
    else if (q.rx_full && q.ien[ucs_pkg::IEN_RX])
      src = ucs_pkg::SRC_RX;
    else if (q.tx_pend && q.ien[ucs_pkg::IEN_TX])
      src = ucs_pkg::SRC_TX;
    else if (q.ms_pend && q.ien[ucs_pkg::IEN_MS])
      src = ucs_pkg::SRC_MS;
    else
      src = ucs_pkg::SRC_NONE;
  end

  // Next-state logic for all registers and flags.
  always_comb
  begin
    d = q;
    d.hr_s1 = hw_reset_i;
    d.hr_s2 = q.hr_s1;
    // Hardware events set; host accesses clear; set wins in same cycle.
    d.mdelta = q.mdelta | modem_delta_i;
    if (rd_ev && addr_i == ucs_pkg::ADDR_MIS)
      d.mdelta = modem_delta_i;
    if (rd_ev && addr_i == ucs_pkg::ADDR_MIS)
      d.ms_pend = 1'b0;
    if (|modem_delta_i)
      d.ms_pend = 1'b1;
    if (rd_ev && addr_i == ucs_pkg::ADDR_LST)
      d.ls_pend = 1'b0;
    if (rd_ev && addr_i == ucs_pkg::ADDR_DATA && !dlab)
    begin
      d.rx_full = 1'b0;
      d.err     = '0;
    end
    if (rx_valid_i)
    begin
      if (q.rx_full && !(rd_ev && addr_i == ucs_pkg::ADDR_DATA && !dlab))
        d.err[0] = 1'b1;
      else
      begin
        d.rxh     = rx_data_i;
        d.rx_full = 1'b1;
        d.err     = rx_err_i;
      end
      d.ls_pend = d.ls_pend | (|d.err);
    end
    // Transmit ready: set while empty and enabled, cleared per rules.
    if (wr_ev && addr_i == ucs_pkg::ADDR_DATA && !dlab)
      d.tx_pend = 1'b0;
    if (rd_ev && addr_i == ucs_pkg::ADDR_ISRC && !q.ien[ucs_pkg::IEN_TX])
      d.tx_pend = 1'b0;
    if (thr_empty && !q.tx_pend && f_valid != 1'b1
        && !(wr_ev && addr_i == ucs_pkg::ADDR_DATA && !dlab)
        && (q.ien[ucs_pkg::IEN_TX] || (wr_ev && addr_i == ucs_pkg::ADDR_IEN
        && !dlab && wdata_i[ucs_pkg::IEN_TX])))
      d.tx_pend = 1'b1;
    if (wr_ev)
    begin
      case (addr_i)
        ucs_pkg::ADDR_DATA:
          if (dlab)
            d.dll = wdata_i;
        ucs_pkg::ADDR_IEN:
          if (dlab)
            d.divisor_high = wdata_i;
          else
            d.ien = wdata_i & ucs_pkg::IEN_WMASK;
        ucs_pkg::ADDR_LFC:
          d.lfc = wdata_i;
        ucs_pkg::ADDR_MOC:
          if (spec)
            d.moc = wdata_i & ucs_pkg::MOC_WMASK;
          else
            d.moc = (wdata_i & ucs_pkg::MOC_WMASK & ~ucs_pkg::MOC_SPEC_BITS)
                    | (q.moc & ucs_pkg::MOC_SPEC_BITS);
        ucs_pkg::ADDR_SCR:
          d.scr = wdata_i;
        default:
          d.scr = q.scr;
      endcase
    end
    // Read data is registered and presented the cycle after the strobe.
    d.rdata = 8'h00;
    if (rd_ev)
    begin
      case (addr_i)
        ucs_pkg::ADDR_DATA:
          d.rdata = dlab ? q.dll : q.rxh;
        ucs_pkg::ADDR_IEN:
          d.rdata = dlab ? q.divisor_high : q.ien;
        ucs_pkg::ADDR_ISRC:
          d.rdata = {4'h0, src};
        ucs_pkg::ADDR_LFC:
          d.rdata = q.lfc;
        ucs_pkg::ADDR_MOC:
          d.rdata = spec ? q.moc : (q.moc & ~8'h80);
        ucs_pkg::ADDR_LST:
          d.rdata = lst;
        ucs_pkg::ADDR_MIS:
          d.rdata = {modem_level_i, q.mdelta};
        ucs_pkg::ADDR_SCR:
          d.rdata = q.scr;
        default:
          d.rdata = 8'h00;
      endcase
    end
  end

  // Single state register; soft reset never reaches here.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q     <= '0;
      q.scr <= ucs_pkg::SCR_RESET;
    end
    else
      q <= d;
  end

  // Format decode for the shifters.
  assign char_len_o = ucs_pkg::DATA_LEN_BASE + {2'b00, q.lfc[1:0]};
  always_comb
  begin
    if (!q.lfc[ucs_pkg::LFC_STOP])
      stop_halves_o = ucs_pkg::STOP_ONE;
    else if (q.lfc[1:0] == 2'b00)
      stop_halves_o = ucs_pkg::STOP_ONE_HALF;
    else
      stop_halves_o = ucs_pkg::STOP_TWO;
  end
  assign parity_en_o     = q.lfc[ucs_pkg::LFC_PEN];
  assign parity_even_o   = q.lfc[ucs_pkg::LFC_EVEN];
  assign parity_forced_o = q.lfc[ucs_pkg::LFC_FORCE];
  assign parity_force_val_o = !q.lfc[ucs_pkg::LFC_EVEN];
  assign tx_break_o = q.lfc[ucs_pkg::LFC_BRK];
  assign divisor_o  = {q.divisor_high, q.dll};
  assign rdata_o    = q.rdata;

  // Modem outputs and loopback.
  assign loopback_o   = q.moc[ucs_pkg::MOC_LOOP];
  assign power_down_o = spec && q.moc[ucs_pkg::MOC_PDN];
  assign dtr_n_o = !q.moc[ucs_pkg::MOC_DTR];
  assign rts_n_o = !q.moc[ucs_pkg::MOC_RTS];
  assign ring_indicator_in_n_o = !q.moc[ucs_pkg::MOC_AUX1];
  assign carrier_detect_in_n_o = !q.moc[ucs_pkg::MOC_AUX2];
  assign irq_o = (src != ucs_pkg::SRC_NONE);
  // Pin enable is active low; loopback keeps the pin released.
  assign irq_oe_n_o = !(q.moc[ucs_pkg::MOC_AUX2] && !loopback_o);
  // Soft reset only in special mode and outside loopback.
  assign reset_buf_o = q.hr_s2 || (spec && !loopback_o
                       && q.moc[ucs_pkg::MOC_AUX1]);

  src_prio_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (q.ls_pend && q.ien[ucs_pkg::IEN_LS]) |-> src == ucs_pkg::SRC_LS)
    else $error("line status not top priority");
  src_none_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (src == ucs_pkg::SRC_NONE) |-> !irq_o)
    else $error("irq raised with nothing pending");
  rx_ready_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (rx_valid_i && !q.rx_full) |=> (lst[0] && q.rxh == $past(rx_data_i)))
    else $error("received byte not held");
  overrun_keep_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (rx_valid_i && q.rx_full && !rd_ev) |=> (q.err[0] && $stable(q.rxh)))
    else $error("overrun lost or corrupted data");
  lst_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (rd_ev && addr_i == ucs_pkg::ADDR_LST && !rx_valid_i) |=> !q.ls_pend)
    else $error("line status read did not clear");
  ms_gate_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !q.ien[ucs_pkg::IEN_MS] |-> src != ucs_pkg::SRC_MS || !q.ms_pend)
    else $error("modem interrupt while disabled");
  ms_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (rd_ev && addr_i == ucs_pkg::ADDR_MIS && !(|modem_delta_i))
    |=> !q.ms_pend)
    else $error("modem status read did not clear");
  pdn_gate_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    power_down_o |-> spec)
    else $error("power down outside special mode");
  tx_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_ev && addr_i == ucs_pkg::ADDR_DATA && !dlab) |=> !q.tx_pend)
    else $error("transmit ready not cleared by load");
endmodule // ucs_ctrl

// ===== verif/ucs_tx_shifter.sv
// Behavioural model of the transmit shift register behind the holding FIFO.
`timescale 1ns/1ps
module ucs_tx_shifter #(
  parameter int SHIFT_CYCLES = 12
) (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       stall_i,
  output logic            ready_o,
  output logic            idle_o,
  output logic            got_o,
  output logic [7:0]      got_data_o
);
  int unsigned cnt_q;

  // A byte is only taken while the shifter is empty; stall lets the bench
  // hold the FIFO full to see it refuse.
  assign ready_o = (cnt_q == 0) && !stall_i;
  assign idle_o  = (cnt_q == 0);

  // Each taken byte keeps the shifter busy for a whole character time.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_q      <= 0;
      got_o      <= 1'b0;
      got_data_o <= 8'h00;
    end
    else
    begin
      got_o <= 1'b0;
      if (valid_i && ready_o)
      begin
        cnt_q      <= SHIFT_CYCLES;
        got_o      <= 1'b1;
        got_data_o <= data_i;
      end
      else if (cnt_q != 0)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule // ucs_tx_shifter

// ===== verif/test_uart_control_status_logic.sv
// Self-checking testbench of the UART control and status logic.
`timescale 1ns/1ps
module test_uart_control_status_logic;
  logic clock_i = 1'b0, rstn_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rx_data_i = 8'h00, rdata_o, tx_data_o, got_d;
  logic rx_valid_i = 1'b0, hw_reset_i = 1'b0, stall = 1'b0, got;
  logic [3:0] rx_err_i = 4'h0, modem_delta_i = 4'h0, modem_level_i = 4'h0;
  logic tx_valid_o, tx_ready_i, tx_hold_ready_o, tx_idle_i, loopback_o;
  logic [3:0] char_len_o;
  logic [2:0] stop_halves_o;
  logic parity_en_o, parity_even_o, parity_forced_o, parity_force_val_o;
  logic tx_break_o, power_down_o, dtr_n_o, rts_n_o, irq_o, irq_oe_n_o;
  logic ring_indicator_in_n_o, carrier_detect_in_n_o, reset_buf_o;
  logic [15:0] divisor_o;
  int fails = 0;
  int n_checks = 0;
  int i;
  logic [31:0] seed = 32'h30D3A21B;
  logic [7:0] exp_q[$], msk_q[$], txq[$], e, m;
  logic rd_d = 1'b0;
  logic [2:0] ra [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [7:0] rv [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hFF};

  ucs_ctrl #(.FIFO_DEPTH(8)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .rd_i(rd_i),
    .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .tx_hold_ready_o(tx_hold_ready_o), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_err_i(rx_err_i), .tx_idle_i(tx_idle_i),
    .modem_delta_i(modem_delta_i), .modem_level_i(modem_level_i),
    .char_len_o(char_len_o), .stop_halves_o(stop_halves_o),
    .parity_en_o(parity_en_o), .parity_even_o(parity_even_o),
    .parity_forced_o(parity_forced_o),
    .parity_force_val_o(parity_force_val_o), .tx_break_o(tx_break_o),
    .divisor_o(divisor_o), .loopback_o(loopback_o),
    .power_down_o(power_down_o), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o),
    .ring_indicator_in_n_o(ring_indicator_in_n_o),
    .carrier_detect_in_n_o(carrier_detect_in_n_o), .irq_o(irq_o),
    .irq_oe_n_o(irq_oe_n_o), .reset_buf_o(reset_buf_o),
    .hw_reset_i(hw_reset_i));

  ucs_tx_shifter #(.SHIFT_CYCLES(12)) partner (
    .clock_i(clock_i), .rstn_i(rstn_i), .valid_i(tx_valid_o),
    .data_i(tx_data_o), .stall_i(stall), .ready_o(tx_ready_i),
    .idle_o(tx_idle_i), .got_o(got), .got_data_o(got_d));

  always #5 clock_i = ~clock_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
    n_checks++;
    if (got_v !== exp_v)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Strobes are held one cycle, then one idle cycle keeps drivers apart.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    tick(1);
    wr_i = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] d,
                    input logic [7:0] mk);
    addr_i = a;
    rd_i = 1'b1;
    exp_q.push_back(d);
    msk_q.push_back(mk);
    tick(1);
    rd_i = 1'b0;
    tick(1);
  endtask

  task automatic rx(input logic [7:0] d, input logic [3:0] er);
    rx_data_i = d;
    rx_err_i = er;
    rx_valid_i = 1'b1;
    tick(1);
    rx_valid_i = 0;
    tick(1);
  endtask

  // Read data stands in the cycle after the strobe; it is looked at on the
  // falling edge so that it has settled. Popped bytes must leave the FIFO
  // in the order they were written.
  always @(negedge clock_i)
  begin
    rd_d <= rd_i;
    if (rd_d)
    begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      chk(rdata_o & m, e & m);
    end
    if (got)
      chk(got_d, (txq.size() != 0) ? txq.pop_front() : ~got_d);
  end

  initial
  begin
    #900_000;
    fails++;
    end_sim();
  end

  initial
  begin
    repeat (20) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    tick(1);
    chk({dtr_n_o, rts_n_o, irq_oe_n_o, reset_buf_o}, 8'h0E);
    for (i = 0; i < 6; i++)
      rd(ra[i], rv[i], 8'hFF);
    // Every length and stop code, with random parity selections.
    for (i = 0; i < 8; i++)
    begin
      seed = xs(seed);
      e = {2'b00, seed[1:0], 1'b1, i[2:0]};
      wr(ucs_pkg::ADDR_LFC, e);
      chk({4'h0, char_len_o}, 8'h05 + e[1:0]);
      chk({5'h0, stop_halves_o}, !e[2] ? 8'h2 : (e[1:0] == 0 ? 8'h3 : 8'h4));
      chk({parity_en_o, parity_even_o, parity_forced_o}, {1'b1, e[4], e[5]});
      if (e[5])
        chk({7'h0, parity_force_val_o}, {7'h0, ~e[4]});
    end
    wr(ucs_pkg::ADDR_LFC, 8'h40);
    chk({7'h0, tx_break_o}, 8'h01);
    modem_level_i = seed[11:8];
    wr(ucs_pkg::ADDR_LFC, 8'h83);
    wr(ucs_pkg::ADDR_DATA, seed[23:16]);
    wr(ucs_pkg::ADDR_IEN, seed[31:24]);
    chk({7'h0, tx_break_o}, 8'h00);
    chk(divisor_o[15:8], seed[31:24]);
    chk(divisor_o[7:0], seed[23:16]);
    wr(ucs_pkg::ADDR_LFC, 8'h03);
    rd(ucs_pkg::ADDR_IEN, 8'h00, 8'hFF);
    // Special bits refused without special mode; loopback keeps the interrupt pin released.
    wr(ucs_pkg::ADDR_MOC, 8'hFF);
    rd(ucs_pkg::ADDR_MOC, 8'h1B, 8'hFF);
    chk({dtr_n_o, rts_n_o, loopback_o, ring_indicator_in_n_o,
         carrier_detect_in_n_o, irq_oe_n_o, power_down_o, reset_buf_o},
        8'h34);
    wr(ucs_pkg::ADDR_IEN, 8'h20);
    wr(ucs_pkg::ADDR_MOC, 8'h8C);
    rd(ucs_pkg::ADDR_MOC, 8'h8C, 8'hFF);
    chk({dtr_n_o, rts_n_o, loopback_o, irq_oe_n_o, power_down_o,
         reset_buf_o}, 8'h33);
    wr(ucs_pkg::ADDR_IEN, 8'h00);
    chk({power_down_o, reset_buf_o}, 8'h00);
    hw_reset_i = 1'b1;
    tick(3);
    chk({7'h0, reset_buf_o}, 8'h01);
    hw_reset_i = 1'b0;
    tick(3);
    chk({7'h0, reset_buf_o}, 8'h00);
    // Interrupt priority, overrun and the clearing paths.
    wr(ucs_pkg::ADDR_IEN, 8'h0F);
    rd(ucs_pkg::ADDR_ISRC, 8'h02, 8'hFF);
    chk({irq_o, irq_oe_n_o}, 8'h02);
    seed = xs(seed);
    rx(seed[7:0], 4'h0);
    rd(ucs_pkg::ADDR_ISRC, 8'h04, 8'hFF);
    rd(ucs_pkg::ADDR_LST, 8'h61, 8'hFF);
    rx(seed[15:8], 4'h0);
    rd(ucs_pkg::ADDR_ISRC, 8'h06, 8'hFF);
    rd(ucs_pkg::ADDR_LST, 8'h63, 8'hFF);
    rd(ucs_pkg::ADDR_ISRC, 8'h04, 8'hFF);
    rd(ucs_pkg::ADDR_LST, 8'h63, 8'hFF);
    rd(ucs_pkg::ADDR_DATA, seed[7:0], 8'hFF);
    rd(ucs_pkg::ADDR_ISRC, 8'h02, 8'hFF);
    rd(ucs_pkg::ADDR_LST, 8'h60, 8'hFF);
    rx(seed[23:16], seed[27:24] | 4'h8);
    rd(ucs_pkg::ADDR_ISRC, 8'h06, 8'hFF);
    rd(ucs_pkg::ADDR_LST, {3'b011, seed[27:24] | 4'h8, 1'b1}, 8'hFF);
    rd(ucs_pkg::ADDR_DATA, seed[23:16], 8'hFF);
    rd(ucs_pkg::ADDR_LST, 8'h60, 8'hFF);
    wr(ucs_pkg::ADDR_IEN, 8'h05);
    modem_delta_i = 4'h4;
    tick(1);
    modem_delta_i = 4'h0;
    rd(ucs_pkg::ADDR_ISRC, 8'h01, 8'hFF);
    wr(ucs_pkg::ADDR_IEN, 8'h0D);
    rd(ucs_pkg::ADDR_ISRC, 8'h00, 8'hFF);
    rd(ucs_pkg::ADDR_MIS, 8'h04, 8'h0F);
    rd(ucs_pkg::ADDR_ISRC, 8'h01, 8'hFF);
    chk({7'h0, irq_o}, 8'h00);
    // Fill the FIFO past full while the shifter stalls, then drain it.
    wr(ucs_pkg::ADDR_IEN, 8'h0F);
    rd(ucs_pkg::ADDR_ISRC, 8'h02, 8'hFF);
    stall = 1'b1;
    for (i = 0; i < 9; i++)
    begin
      seed = xs(seed);
      if (i < 8)
        txq.push_back(seed[7:0]);
      chk({7'h0, tx_hold_ready_o}, {7'h0, i < 8});
      wr(ucs_pkg::ADDR_DATA, seed[7:0]);
    end
    rd(ucs_pkg::ADDR_ISRC, 8'h01, 8'hFF);
    rd(ucs_pkg::ADDR_LST, 8'h00, 8'h60);
    stall = 1'b0;
    for (i = 0; i < 500 && (txq.size() != 0 || !tx_idle_i); i++)
      tick(1);
    if (i == 500)
    begin
      fails++;
      end_sim();
    end
    rd(ucs_pkg::ADDR_LST, 8'h60, 8'h60);
    rd(ucs_pkg::ADDR_ISRC, 8'h02, 8'hFF);
    end_sim();
  end
endmodule // test_uart_control_status_logic
